// file: rrdc_consts.vh
`ifndef RRDC_CONSTS_VH
`define RRDC_CONSTS_VH

// ======================================================================
// Register byte offsets
`define RRDC_CTRL_OFS        12'h000
`define RRDC_STAT_OFS        12'h004
`define RRDC_CHARS_OFS       12'h008
`define RRDC_ERRS_OFS        12'h00c

// ======================================================================
// Control field positions and reset values
`define RRDC_CTRL_RATE_LSB   0
`define RRDC_CTRL_RATE_MSB   2
`define RRDC_CTRL_P10_BIT    3
`define RRDC_CTRL_RST        4'h0

// ======================================================================
// Status field positions
`define RRDC_STAT_TX_BIT     0
`define RRDC_STAT_RATE_LSB   1
`define RRDC_STAT_RATE_MSB   3
`define RRDC_STAT_RSVD_BIT   4
`define RRDC_STAT_BUSY_BIT   5

// ======================================================================
// Rate codes
`define RRDC_RATE_38400      3'h0
`define RRDC_RATE_19200      3'h1
`define RRDC_RATE_9600       3'h2
`define RRDC_RATE_4800       3'h3
`define RRDC_RATE_2400       3'h4
`define RRDC_RATE_1200       3'h5
`define RRDC_RATE_600        3'h6
`define RRDC_RATE_RSVD       3'h7
`define RRDC_RATE_DEFAULT    3'h2

// ======================================================================
// Clock and timing
`define RRDC_CLK_HZ          200000000
`define RRDC_BAUD_FASTEST    38400
`define RRDC_TA_38400_US     500
`define RRDC_TA_19200_US     1000
`define RRDC_TA_9600_US      2000
`define RRDC_TA_4800_US      4000
`define RRDC_TA_2400_US      7000
`define RRDC_TA_1200_US      14000
`define RRDC_TA_600_US       28000
`define RRDC_US_PER_S        1000000

`endif

// file: rrdc_top.v
`timescale 1ns/100ps
`include "rrdc_consts.vh"

module rrdc_top #(
    parameter BIT_CYC  = `RRDC_CLK_HZ / `RRDC_BAUD_FASTEST,
    parameter TA0_CYC  = `RRDC_TA_38400_US * (`RRDC_CLK_HZ / `RRDC_US_PER_S),
    parameter TA1_CYC  = `RRDC_TA_19200_US * (`RRDC_CLK_HZ / `RRDC_US_PER_S),
    parameter TA2_CYC  = `RRDC_TA_9600_US * (`RRDC_CLK_HZ / `RRDC_US_PER_S),
    parameter TA3_CYC  = `RRDC_TA_4800_US * (`RRDC_CLK_HZ / `RRDC_US_PER_S),
    parameter TA4_CYC  = `RRDC_TA_2400_US * (`RRDC_CLK_HZ / `RRDC_US_PER_S),
    parameter TA5_CYC  = `RRDC_TA_1200_US * (`RRDC_CLK_HZ / `RRDC_US_PER_S),
    parameter TA6_CYC  = `RRDC_TA_600_US * (`RRDC_CLK_HZ / `RRDC_US_PER_S)
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        rs232_txd,
    output reg         rs232_rxd,
    input  wire        rs485_rxd,
    output reg         rs485_txd,
    output reg         rs485_drv_en,
    output reg         point_to_point_master_slave_protocol_sel10
);

    // ==================================================================
    // Framer states
    localparam ST_IDLE = 3'h0;
    localparam ST_DATA = 3'h1;
    localparam ST_PAR  = 3'h2;
    localparam ST_STOP = 3'h3;
    localparam ST_STRT = 3'h4;

    reg  [3:0]  ctrl_q;
    reg         tx_mode_q;
    reg  [23:0] ta_cnt_q;
    reg  [2:0]  fr_st_q;
    reg  [23:0] fr_cnt_q;
    reg  [2:0]  fr_bit_q;
    reg         fr_par_q;
    reg  [15:0] chars_q;
    reg  [15:0] errs_q;
    reg  [2:0]  rate;
    reg  [23:0] ta_lim;
    wire [23:0] bit_cyc;
    wire [23:0] half_cyc;
    wire        acc;
    wire        wr_ctrl;
    wire        wr_errs;
    wire        fr_tick;
    reg  [31:0] rd_val;
    reg         rd_err;
    wire        setup;
    wire [31:0] stat_val;

    // ==================================================================
    // Rate selection
    // Code 111 is not a defined rate; falling back to 9600 keeps the bit
    // timer and the turnaround on a matching pair instead of a guess.
    // reserved code fallback
    always @* begin
        if (ctrl_q[`RRDC_CTRL_RATE_MSB:`RRDC_CTRL_RATE_LSB] == `RRDC_RATE_RSVD) begin
            rate = `RRDC_RATE_DEFAULT;
        end else begin
            rate = ctrl_q[`RRDC_CTRL_RATE_MSB:`RRDC_CTRL_RATE_LSB];
        end
    end

    always @* begin
        case (rate)
            `RRDC_RATE_38400: ta_lim = TA0_CYC[23:0];
            `RRDC_RATE_19200: ta_lim = TA1_CYC[23:0];
            `RRDC_RATE_9600:  ta_lim = TA2_CYC[23:0];
            `RRDC_RATE_4800:  ta_lim = TA3_CYC[23:0];
            `RRDC_RATE_2400:  ta_lim = TA4_CYC[23:0];
            `RRDC_RATE_1200:  ta_lim = TA5_CYC[23:0];
            `RRDC_RATE_600:   ta_lim = TA6_CYC[23:0];
            default:          ta_lim = TA2_CYC[23:0];
        endcase
    end

    // One divider serves all seven rates by shifting, at the cost that the
    // slower rates inherit the rounding error of the fastest one.
    // each code halves the rate
    assign bit_cyc  = BIT_CYC[23:0] << rate;
    assign half_cyc = {1'b0, bit_cyc[23:1]};

    // ==================================================================
    // Direction control
    // The count starts again on every low sample, so the turnaround is
    // measured from the last activity, not from the end of the stop bit.
    // A character that arrives just as the timer runs out keeps the
    // driver on, since the low sample takes priority over the drop.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_mode_q <= 1'b0;
            ta_cnt_q  <= 24'h000000;
        end else if (!rs232_txd) begin
            tx_mode_q <= 1'b1;
            ta_cnt_q  <= 24'h000000;
        end else if (tx_mode_q) begin
            // leave only after full idle time
            if (ta_cnt_q >= ta_lim - 24'h000001) begin
                tx_mode_q <= 1'b0;
                ta_cnt_q  <= 24'h000000;
            end else begin
                ta_cnt_q <= ta_cnt_q + 24'h000001;
            end
        end
    end

    // Outputs are registered, so both data paths carry one cycle of latency.
    // Forcing the receive line idle while driving hides the echo of our own
    // transmission from the RS-232 device.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rs485_txd    <= 1'b1;
            rs485_drv_en <= 1'b0;
            rs232_rxd    <= 1'b1;
        end else begin
            rs485_drv_en <= tx_mode_q | ~rs232_txd;
            rs485_txd    <= rs232_txd;
            // receive path only while not transmitting
            if (tx_mode_q | ~rs232_txd) begin
                rs232_rxd <= 1'b1;
            end else begin
                rs232_rxd <= rs485_rxd;
            end
        end
    end

    // ==================================================================
    // Character checker on the RS-232 transmit line
    // The checker only counts characters and framing and parity faults for software.
    // Data passes to the bus untouched, so a bad frame is still forwarded
    // and the direction logic never waits on the checker.
    // Reloads are one short of the period because the zero count takes a
    // cycle of its own; the sample point then stays in mid-bit for all bits.
    assign fr_tick = (fr_cnt_q == 24'h000000);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fr_st_q  <= ST_IDLE;
            fr_cnt_q <= 24'h000000;
            fr_bit_q <= 3'h0;
            fr_par_q <= 1'b0;
            chars_q  <= 16'h0000;
            errs_q   <= 16'h0000;
        end else begin
            if (!fr_tick) begin
                fr_cnt_q <= fr_cnt_q - 24'h000001;
            end
            case (fr_st_q)
                ST_IDLE: begin
                    if (!rs232_txd) begin
                        fr_st_q  <= ST_STRT;
                        fr_cnt_q <= half_cyc - 24'h000001;
                    end
                end
                ST_STRT: begin
                    if (fr_tick) begin
                        // A glitch that does not hold to mid-bit is dropped.
                        fr_st_q  <= rs232_txd ? ST_IDLE : ST_DATA;
                        fr_cnt_q <= bit_cyc - 24'h000001;
                        fr_bit_q <= 3'h0;
                        fr_par_q <= 1'b0;
                    end
                end
                ST_DATA: begin
                    if (fr_tick) begin
                        fr_par_q <= fr_par_q ^ rs232_txd;
                        fr_bit_q <= fr_bit_q + 3'h1;
                        fr_cnt_q <= bit_cyc - 24'h000001;
                        if (fr_bit_q == 3'h7) begin
                            // 10-bit format has no parity bit
                            fr_st_q <= ctrl_q[`RRDC_CTRL_P10_BIT] ? ST_STOP : ST_PAR;
                        end
                    end
                end
                ST_PAR: begin
                    if (fr_tick) begin
                        fr_par_q <= fr_par_q ^ rs232_txd;
                        fr_cnt_q <= bit_cyc - 24'h000001;
                        fr_st_q  <= ST_STOP;
                    end
                end
                ST_STOP: begin
                    if (fr_tick) begin
                        fr_st_q <= ST_IDLE;
                        chars_q <= chars_q + 16'h0001;
                        // parity checked in 11-bit format only
                        if (!rs232_txd || (fr_par_q && !ctrl_q[`RRDC_CTRL_P10_BIT])) begin
                            errs_q <= errs_q + 16'h0001;
                        end
                    end
                end
                default: fr_st_q <= ST_IDLE;
            endcase
            // A count event wins over the software clear.
            if (wr_errs && !(fr_st_q == ST_STOP && fr_tick)) begin
                chars_q <= 16'h0000;
                errs_q  <= 16'h0000;
            end
        end
    end

    // ==================================================================
    // APB slave
    assign acc     = psel & penable & pready;
    assign wr_ctrl = acc & pwrite & (paddr == `RRDC_CTRL_OFS);
    assign wr_errs = acc & pwrite & (paddr == `RRDC_ERRS_OFS);

    // Status word: busy, reserved code chosen, effective rate, transmit mode.
    assign stat_val = {26'h0, (fr_st_q != ST_IDLE),
                       (ctrl_q[`RRDC_CTRL_RATE_MSB:`RRDC_CTRL_RATE_LSB] == `RRDC_RATE_RSVD),
                       rate, tx_mode_q};

    // Unaligned and unmapped offsets fall to the default branch and are refused.
    always @* begin
        rd_val = 32'h00000000;
        rd_err = 1'b0;
        case (paddr)
            `RRDC_CTRL_OFS:  rd_val = {28'h0000000, ctrl_q};
            `RRDC_STAT_OFS:  rd_val = stat_val;
            `RRDC_CHARS_OFS: rd_val = {16'h0000, chars_q};
            `RRDC_ERRS_OFS:  rd_val = {16'h0000, errs_q};
            default:         rd_err = 1'b1;
        endcase
        // Status and the character counter are read-only; writing them is an error.
        if (pwrite && paddr == `RRDC_STAT_OFS) begin
            rd_err = 1'b1;
        end
        if (pwrite && paddr == `RRDC_CHARS_OFS) begin
            rd_err = 1'b1;
        end
    end

    // ==================================================================
    // Bus response
    // Every access gets one access phase with no wait state. Read data and
    // the error flag are decided in the setup cycle, so both stand through
    // the whole access phase.
    assign setup = psel & ~penable & ~pready;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= setup;
            pslverr <= setup & rd_err;
            if (setup && !pwrite) begin
                prdata <= rd_val;
            end
        end
    end

    // ==================================================================
    // Control register
    // rate switch field
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `RRDC_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_q <= pwdata[3:0];
        end
    end

    // ==================================================================
    // Format select
    // The pin lags the register by one cycle so that it comes straight
    // from a flip-flop.
    // format select to the controller
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            point_to_point_master_slave_protocol_sel10 <= 1'b0;
        end else begin
            point_to_point_master_slave_protocol_sel10 <= ctrl_q[`RRDC_CTRL_P10_BIT];
        end
    end

endmodule

// file: rrdc_top_asserts.sv
`timescale 1ns/100ps
`include "rrdc_consts.vh"
module rrdc_top_asserts #(
    parameter int TA0_CYC = 40,
    parameter int TA1_CYC = 80,
    parameter int TA2_CYC = 160,
    parameter int TA3_CYC = 320,
    parameter int TA4_CYC = 560,
    parameter int TA5_CYC = 1120,
    parameter int TA6_CYC = 2240
) (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        rs232_txd,
    input wire        rs232_rxd,
    input wire        rs485_rxd,
    input wire        rs485_txd,
    input wire        rs485_drv_en
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [23:0] idle_q;
    logic [2:0]  code_q;
    int          ta;
    wire         ack = psel && penable && pready;
    // Idle counter restarts on each low sample, matching how turnaround is measured.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_q <= 24'h0;
            code_q <= 3'h0;
        end else begin
            if (!rs232_txd)
                idle_q <= 24'h0;
            else if (idle_q != 24'hffffff)
                idle_q <= idle_q + 24'h1;
            if (ack && pwrite && !pslverr && paddr == `RRDC_CTRL_OFS)
                code_q <= pwdata[2:0];
        end
    end
    always_comb begin
        case (code_q)
            3'h0: ta = TA0_CYC;
            3'h1: ta = TA1_CYC;
            3'h3: ta = TA3_CYC;
            3'h4: ta = TA4_CYC;
            3'h5: ta = TA5_CYC;
            3'h6: ta = TA6_CYC;
            default: ta = TA2_CYC;
        endcase
    end
    sequence s_setup;
        psel && !penable;
    endsequence
    chk_tx_entry: assert property (!rs232_txd |=> rs485_drv_en)
        else $error("driver not enabled after activity");
    chk_txd_copy: assert property ($past(presetn) |-> rs485_txd == $past(rs232_txd))
        else $error("bus data is not the delayed transmit line");
    chk_rx_block: assert property (rs485_drv_en && $past(rs485_drv_en) |-> rs232_rxd)
        else $error("receive path open while transmitting");
    chk_rx_pass: assert property (!rs485_drv_en && !$past(rs485_drv_en) && $past(presetn)
        |-> rs232_rxd == $past(rs485_rxd))
        else $error("receive path does not follow bus");
    chk_tx_stay: assert property (rs485_drv_en && idle_q < ta |=> rs485_drv_en)
        else $error("left transmit mode early");
    chk_fall_time: assert property ($fell(rs485_drv_en) |->
        idle_q >= ta && idle_q <= ta + 2)
        else $error("turnaround length wrong");
    chk_zero_wait: assert property (s_setup |=> pready)
        else $error("access phase not answered at once");
    chk_bad_refuse: assert property (ack && (paddr > `RRDC_ERRS_OFS || pwrite &&
        (paddr == `RRDC_STAT_OFS || paddr == `RRDC_CHARS_OFS)) |-> pslverr)
        else $error("illegal access not refused");
endmodule
bind rrdc_top rrdc_top_asserts #(.TA0_CYC(TA0_CYC), .TA1_CYC(TA1_CYC), .TA2_CYC(TA2_CYC),
    .TA3_CYC(TA3_CYC), .TA4_CYC(TA4_CYC), .TA5_CYC(TA5_CYC), .TA6_CYC(TA6_CYC)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rs232_txd(rs232_txd), .rs232_rxd(rs232_rxd), .rs485_rxd(rs485_rxd),
    .rs485_txd(rs485_txd), .rs485_drv_en(rs485_drv_en));

// file: rrdc_far_model.sv
`timescale 1ns/100ps
module rrdc_far_model (
    input  wire  pclk,
    output logic rs232_txd,
    output logic rs485_rxd
);
    initial begin
        rs232_txd = 1'b1;
        rs485_rxd = 1'b1;
    end
    // start data parity
    // Returns as the stop level starts, so the caller can time the idle gap itself.
    task automatic frame(input logic to485, input logic [7:0] d, input logic bad,
                         input int bitc);
        logic [9:0] f;
        f = {(^d) ^ bad, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            if (to485) rs485_rxd <= f[i];
            else rs232_txd <= f[i];
            repeat (bitc) @(posedge pclk);
        end
        if (to485) rs485_rxd <= 1'b1;
        else rs232_txd <= 1'b1;
    endtask
endmodule

// file: rrdc_top_test.sv
`timescale 1ns/100ps
`include "rrdc_consts.vh"
module rrdc_top_test;
    localparam int TA[8] = '{40, 80, 160, 320, 560, 1120, 2240, 160};
    localparam int BITC = 8;
    logic        pclk, presetn, psel, penable, pwrite, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, rs232_rxd, rs485_txd, drv_en, sel10;
    wire         rs232_txd, rs485_rxd;
    int          err_total, n_checks, n, bitc;
    rrdc_top #(.BIT_CYC(BITC), .TA0_CYC(TA[0]), .TA1_CYC(TA[1]), .TA2_CYC(TA[2]),
        .TA3_CYC(TA[3]), .TA4_CYC(TA[4]), .TA5_CYC(TA[5]), .TA6_CYC(TA[6])) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rs232_txd(rs232_txd), .rs232_rxd(rs232_rxd), .rs485_rxd(rs485_rxd),
        .rs485_txd(rs485_txd), .rs485_drv_en(drv_en),
        .point_to_point_master_slave_protocol_sel10(sel10));
    rrdc_far_model far (.pclk(pclk), .rs232_txd(rs232_txd), .rs485_rxd(rs485_rxd));
    always #2.5 pclk = ~pclk;
    task complete_run;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            err_total++;
            complete_run;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    initial begin
        pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
        err_total = 0;
        n_checks = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, `RRDC_CTRL_OFS, 0);
        chk("ctrl reset", rd, 0);
        chk("idle mode", {drv_en, rs232_rxd}, 1);
        $display("test reset done");
        for (int c = 0; c < 8; c++) begin
            apb(1, `RRDC_CTRL_OFS, c);
            apb(0, `RRDC_STAT_OFS, 0);
            chk("rate", 32'(rd[4:1]), {c == 7, (c == 7) ? 3'h2 : c[2:0]});
            bitc = BITC << ((c == 7) ? 2 : c);
            @(posedge pclk);
            fork
                far.frame(0, 8'h55, c == 1, bitc);
                begin
                    repeat (bitc / 2) @(posedge pclk);
                    chk("bus start", 32'(rs485_txd), 0);
                end
            join
            chk("tx mode", 32'(drv_en), 1);
            n = 0;
            while (drv_en !== 1'b0 && n < 3000) begin
                @(posedge pclk);
                n++;
            end
            if (c == 1) n = n + bitc;
            chk("turnaround", 32'(n >= TA[c] && n <= TA[c] + 3), 1);
            // answer only once the converter is back in receive mode
            fork
                far.frame(1, 8'ha3, 0, bitc);
                begin
                    repeat (bitc / 2) @(posedge pclk);
                    chk("rx start", 32'(rs232_rxd), 0);
                    repeat (bitc) @(posedge pclk);
                    chk("rx bit0", 32'(rs232_rxd), 1);
                end
            join
            repeat (bitc) @(posedge pclk);
            chk("rx mode", 32'(drv_en), 0);
            apb(0, `RRDC_CHARS_OFS, 0);
            chk("chars", rd, c + 1);
        end
        $display("test rates done");
        apb(0, `RRDC_ERRS_OFS, 0);
        chk("errors", rd, 1);
        apb(1, `RRDC_ERRS_OFS, 0);
        apb(0, `RRDC_CHARS_OFS, 0);
        chk("chars clear", {rd[30:0], err}, 0);
        apb(1, `RRDC_STAT_OFS, 1);
        chk("ro refuse", 32'(err), 1);
        apb(0, 12'h010, 0);
        chk("unmapped", 32'(err), 1);
        apb(1, `RRDC_CTRL_OFS, 32'h8);
        apb(0, `RRDC_CTRL_OFS, 0);
        chk("fmt reg", rd, 32'h8);
        chk("fmt pin", 32'(sel10), 1);
        $display("test access done");
        // odd data makes the tenth bit a valid stop level
        far.frame(0, 8'h01, 0, BITC);
        n = 0;
        while (drv_en !== 1'b0 && n < 3000) begin
            @(posedge pclk);
            n++;
        end
        chk("short turnaround", 32'(n + BITC >= TA[0] && n + BITC <= TA[0] + 3), 1);
        apb(0, `RRDC_CHARS_OFS, 0);
        chk("short chars", rd, 1);
        apb(0, `RRDC_ERRS_OFS, 0);
        chk("short errors", rd, 0);
        $display("test format done");
        complete_run;
    end
endmodule
